// ### design/sync_burst_sram_defines.svh
// constants for the synchronous flow-through burst sram port
// assumes a single 10 MHz clock; included by bare name
`ifndef SYNC_BURST_SRAM_DEFINES_SVH
`define SYNC_BURST_SRAM_DEFINES_SVH

// clock period in ns, for reference by any timing count
`define CLK_PERIOD_NS 100
// full word address, of which the low two bits feed the burst counter
`define ADDR_W 18
`define HI_ADDR_W 16
`define BURST_W 2
// four byte lanes of nine bits each (eight data plus one parity)
`define LANES 4
`define LANE_W 9
`define DATA_W 36
`define MEM_DEPTH 262144
// reset values
`define RST_OFFSET 2'h0
`define RST_HI_ADDR 16'h0000
`define RST_DATA 36'h0_0000_0000

`endif

// ### design/sync_burst_sram_pkg.sv
// types shared by the burst sram port and its burst counter
// assumes the defines header is compiled alongside
package sync_burst_sram_pkg;

    // selection state, one-hot
    typedef enum logic [2:0] {
        ST_DESEL  = 3'h1, // deselected, no access
        ST_FIRST  = 3'h2, // first clock after leaving deselect
        ST_ACTIVE = 3'h4  // selected, burst may continue
    } sel_state_type;

    typedef logic [1:0] burst_offset_type;

endpackage : sync_burst_sram_pkg

// ### design/burst_if.sv
// carrier between the sram port control and its burst counter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface burst_if;
    import sync_burst_sram_pkg::*;
    logic load;                     // capture a new start offset
    burst_offset_type base;         // start offset from the address pins
    logic advance;                  // step to the next location
    logic linear;                   // linear order when high, else interleaved
    burst_offset_type offset;       // current low address bits
    burst_offset_type next_offset;  // value offset takes at the next edge

    modport ctrl (output load, output base, output advance, output linear,
                  input offset, input next_offset);
    modport counter (input load, input base, input advance, input linear,
                     output offset, output next_offset);
endinterface : burst_if

// ### design/burst_counter.sv
// two-bit burst counter with linear or interleaved sequence
// assumes load and advance are never requested together
`timescale 1ns/1ps
module burst_counter
    import sync_burst_sram_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // control side
    burst_if.counter bus
);
    `include "sync_burst_sram_defines.svh"

    burst_offset_type base;
    burst_offset_type count;
    burst_offset_type next_base;
    burst_offset_type next_count;
    burst_offset_type count_inc;

    // next base and advance count; load restarts the sequence
    always_comb begin
        count_inc = count + 2'h1;
        next_base = base;
        next_count = count;
        if (bus.load) begin
            next_base = bus.base;
            next_count = `RST_OFFSET;
        end else if (bus.advance) begin
            next_count = count_inc;
        end
    end

    // offset per order: linear adds, interleaved xors the advance count
    always_comb begin
        if (bus.linear) begin
            bus.offset = base + count;
            bus.next_offset = next_base + next_count;
        end else begin
            bus.offset = base ^ count;
            bus.next_offset = next_base ^ next_count;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            base <= `RST_OFFSET;
            count <= `RST_OFFSET;
        end else begin
            base <= next_base;
            count <= next_count;
        end
    end

    a_count_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!bus.load && !bus.advance) |=> count == $past(count))
        else $error("burst count moved without advance");

    a_count_step: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!bus.load && bus.advance) |=> count == 2'($past(count) + 2'h1))
        else $error("burst count did not step on advance");

    a_order_linear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (bus.load && bus.linear) ##1 (!bus.load && bus.advance && bus.linear)
        |=> bus.offset == 2'($past(bus.base, 2) + 2'h1))
        else $error("linear order did not count up from start");

endmodule : burst_counter

// ### design/sync_burst_sram_port.sv
// flow-through burst sram: strobes, chip selects, burst count, lanes
// assumes controls come from logic on i_mclk; output enable is async
//
// Behaviour
// - strobe low and all selects active: capture address on the clock edge
// - load low two address bits into the burst counter on capture
// - lane written when its active-low select and byte write enable are low
// - global write low writes every lane regardless of lane selects
// - counter increments on edges where advance is low, holds when high
// - advance steps the internal burst address to the next location
// - first select active low; while high the processor strobe is ignored
// - second select active high, takes part in select/deselect
// - third select active low, takes part in select/deselect
// - selects are evaluated only on address-load cycles, ignored mid-burst
// - output enable low drives data pins at once, no clock needed
// - output enable high releases data pins so they accept write data
// - first clock of a read after deselect keeps outputs undriven
// - both strobes low: processor strobe acts, controller strobe ignored
// - static strap: low linear, high interleaved; not changed during use
// - data pins released during write data and while deselected
`timescale 1ns/1ps
module sync_burst_sram_port
    import sync_burst_sram_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // address and strobes
    input wire logic [17:0] i_addr,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_burst_advance_n,
    // chip selects
    input wire logic i_chip_sel_first_n,
    input wire logic i_chip_sel_second,
    input wire logic i_chip_sel_third_n,
    // write qualifiers
    input wire logic i_global_write_n,
    input wire logic i_byte_write_enable_n,
    input wire logic i_lane0_write_select_n,
    input wire logic i_lane1_write_select_n,
    input wire logic i_lane2_write_select_n,
    input wire logic i_lane3_write_select_n,
    // static strap and asynchronous output enable
    input wire logic i_burst_order,
    input wire logic i_output_enable_n,
    // data pins split into in, out and enable
    input wire logic [35:0] i_dq,
    output logic [35:0] o_dq,
    output logic o_dq_oe
);
    `include "sync_burst_sram_defines.svh"

    burst_if bus ();

    sel_state_type state;
    sel_state_type next_state;
    logic [`HI_ADDR_W-1:0] hi_addr;
    logic [`HI_ADDR_W-1:0] next_hi_addr;
    logic rd_drive;
    logic next_rd_drive;
    logic [`DATA_W-1:0] next_dq;
    logic order_meta;
    logic order_sync;
    logic start_proc;
    logic addr_load;
    logic chip_sel;
    logic load_sel;
    logic eff_sel;
    logic wr_now;
    logic [`LANES-1:0] lane_sel_n;
    logic [`LANES-1:0] lane_we;
    logic [`ADDR_W-1:0] wr_addr;
    logic [`ADDR_W-1:0] rd_addr;
    logic [`LANE_W-1:0] mem [0:`MEM_DEPTH-1][0:`LANES-1];

    burst_counter u_counter (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .bus(bus)
    );

    // strap passes two flops; it is static so latency does not matter
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            order_meta <= 1'h1;
            order_sync <= 1'h1;
        end else begin
            order_meta <= i_burst_order;
            order_sync <= order_meta;
        end
    end

    // strobe and select decode
    always_comb begin
        start_proc = !i_processor_addr_strobe_n && !i_chip_sel_first_n;
        addr_load = start_proc || !i_controller_addr_strobe_n;
        chip_sel = !i_chip_sel_first_n && i_chip_sel_second
            && !i_chip_sel_third_n;
        load_sel = addr_load && chip_sel;
        eff_sel = addr_load ? chip_sel : (state != ST_DESEL);
    end

    // lane write enables; a processor-strobe load is always a read
    assign lane_sel_n = {i_lane3_write_select_n, i_lane2_write_select_n,
                         i_lane1_write_select_n, i_lane0_write_select_n};
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : g_lane
            assign lane_we[g] = !i_global_write_n
                || (!i_byte_write_enable_n && !lane_sel_n[g]);
            always_ff @(posedge i_mclk) begin
                if (wr_now && lane_we[g]) begin
                    mem[wr_addr][g] <= i_dq[g*`LANE_W +: `LANE_W];
                end
            end
        end
    endgenerate

    assign wr_now = eff_sel && !start_proc && (|lane_we);
    // a continuation write lands on the stepped address, as the read side does
    assign wr_addr = load_sel ? i_addr : {hi_addr, bus.next_offset};

    // burst counter control
    always_comb begin
        bus.load = load_sel;
        bus.base = i_addr[1:0];
        bus.advance = !addr_load && !i_burst_advance_n
            && (state != ST_DESEL);
        bus.linear = !order_sync;
    end

    // next state, address and read data
    always_comb begin
        next_state = state;
        next_hi_addr = hi_addr;
        if (addr_load) begin
            if (chip_sel) begin
                next_hi_addr = i_addr[17:2];
                next_state = (state == ST_DESEL) ? ST_FIRST : ST_ACTIVE;
            end else begin
                next_state = ST_DESEL;
            end
        end else if (state == ST_FIRST) begin
            next_state = ST_ACTIVE;
        end
        rd_addr = {next_hi_addr, bus.next_offset};
        // read of a location being written this edge returns old data
        next_dq = {mem[rd_addr][3], mem[rd_addr][2], mem[rd_addr][1], mem[rd_addr][0]};
        next_rd_drive = (next_state == ST_ACTIVE) && !wr_now;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_DESEL;
            hi_addr <= `RST_HI_ADDR;
            rd_drive <= 1'h0;
            o_dq <= `RST_DATA;
        end else begin
            state <= next_state;
            hi_addr <= next_hi_addr;
            rd_drive <= next_rd_drive;
            o_dq <= next_dq;
        end
    end

    // pin enable must follow the async enable without a clock edge
    assign o_dq_oe = rd_drive && !i_output_enable_n;

    a_addr_capture: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        load_sel |=> hi_addr == $past(i_addr[17:2]) && bus.offset == $past(i_addr[1:0]))
        else $error("address not captured on selecting load");

    a_ignore_proc: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_chip_sel_first_n && i_controller_addr_strobe_n && state != ST_FIRST)
        |=> state == $past(state) && hi_addr == $past(hi_addr))
        else $error("processor strobe acted with first select high");

    a_global_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !i_global_write_n |-> lane_we == 4'hF)
        else $error("global write did not enable all lanes");

    a_lane_qualify: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_global_write_n && i_byte_write_enable_n) |-> lane_we == 4'h0)
        else $error("lane written without byte write enable");

    a_burst_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (state == ST_ACTIVE && !addr_load) ##1 !addr_load |-> state == ST_ACTIVE)
        else $error("selection changed during burst continuation");

    a_deselect_load: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (addr_load && !chip_sel) |=> state == ST_DESEL && !o_dq_oe)
        else $error("inactive select on load did not deselect");

    a_first_masked: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (state == ST_DESEL && load_sel) |=> !o_dq_oe)
        else $error("outputs driven on first clock after deselect");

    a_oe_release: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_output_enable_n |-> !o_dq_oe)
        else $error("pins driven while output enable high");

    a_write_tristate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        wr_now |=> !o_dq_oe)
        else $error("pins driven in write data phase");

    a_proc_priority: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (start_proc && !i_controller_addr_strobe_n) |-> !wr_now)
        else $error("controller strobe acted beside processor strobe");

endmodule : sync_burst_sram_port

// ### test/sram_host_model.sv
// host-side data driver and pin resolver for the burst sram port
// assumes the bench changes drive and data at the falling clock edge
`timescale 1ns/1ps
module sram_host_model (
    // clock
    input wire logic i_mclk,
    // bench side
    input wire logic i_drive,
    input wire logic [35:0] i_wdata,
    // device side
    input wire logic [35:0] i_dev_dq,
    input wire logic i_dev_oe,
    // resolved pin level
    output logic [35:0] o_wire
);
    logic [35:0] last;

    // released pins show the inverse of the last level, so stale data never matches
    always_comb begin
        if (i_dev_oe) begin
            o_wire = i_dev_dq;
        end else if (i_drive) begin
            o_wire = i_wdata;
        end else begin
            o_wire = ~last;
        end
    end

    // remember the level seen at each edge
    always_ff @(posedge i_mclk) begin
        last <= o_wire;
    end
endmodule : sram_host_model

// ### test/sync_burst_sram_port_bench.sv
// self-checking bench for the burst sram port
// assumes the host model resolves the data pins; inputs move at falling edges
`timescale 1ns/1ps
module sync_burst_sram_port_bench;
    import sync_burst_sram_pkg::*;
    logic clk, nrst, ps, cs, burst_advance_n, gw, byte_write_enable_n, order, oe_n, drv, oe;
    logic [3:0] lane_n;
    logic [2:0] sel;
    logic [17:0] addr;
    logic [35:0] wdata, wire_dq, dq;
    logic [35:0] exp [0:7];
    int n_tests, err_total;

    sync_burst_sram_port dut_u (.i_mclk(clk), .i_nrst(nrst), .i_addr(addr),
        .i_processor_addr_strobe_n(ps), .i_controller_addr_strobe_n(cs),
        .i_burst_advance_n(burst_advance_n), .i_chip_sel_first_n(sel[2]), .i_chip_sel_second(sel[1]),
        .i_chip_sel_third_n(sel[0]), .i_global_write_n(gw), .i_byte_write_enable_n(byte_write_enable_n),
        .i_lane0_write_select_n(lane_n[0]), .i_lane1_write_select_n(lane_n[1]),
        .i_lane2_write_select_n(lane_n[2]), .i_lane3_write_select_n(lane_n[3]),
        .i_burst_order(order), .i_output_enable_n(oe_n), .i_dq(wire_dq), .o_dq(dq),
        .o_dq_oe(oe));
    sram_host_model host_u (.i_mclk(clk), .i_drive(drv), .i_wdata(wdata), .i_dev_dq(dq),
        .i_dev_oe(oe), .o_wire(wire_dq));

    // free-running clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("ERROR %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk

    // all strobes and writes inactive, device selects active
    task automatic idle;
        {ps, cs, burst_advance_n, gw, byte_write_enable_n} = 5'h1F;
        lane_n = 4'hF;
        sel = 3'h2;
        drv = 1'b0;
    endtask : idle

    // strap only moves while reset holds, never during operation
    task automatic rst(input logic m);
        nrst = 1'b0;
        order = m;
        idle();
        oe_n = 1'b1;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        chk(36'(oe), 36'h0);
    endtask : rst

    // controller strobe load with global write, data on the same edge
    task automatic wr(input logic [2:0] a, input logic [35:0] d);
        idle();
        cs = 1'b0;
        gw = 1'b0;
        addr = 18'h00100 | 18'(a);
        drv = 1'b1;
        wdata = d;
        @(negedge clk);
    endtask : wr

    task automatic t_write;
        for (int k = 0; k < 8; k++) begin
            exp[k] = 36'h1_1111_1111 * 36'(k);
            wr(3'(k), exp[k]);
        end
        idle();
        burst_advance_n = 1'b0;
        byte_write_enable_n = 1'b0;
        lane_n = 4'hD;
        drv = 1'b1;
        wdata = 36'hF_FFFF_FFFF;
        @(negedge clk);
        exp[4][17:9] = 9'h1FF;
        byte_write_enable_n = 1'b1;
        lane_n = 4'h0;
        @(negedge clk);
        byte_write_enable_n = 1'b0;
        lane_n = 4'h7;
        @(negedge clk);
        exp[6][35:27] = 9'h1FF;
        // both strobes: processor load wins, so no write happens here
        idle();
        ps = 1'b0;
        cs = 1'b0;
        gw = 1'b0;
        addr = 18'h00100;
        @(negedge clk);
        $display("write test done");
    endtask : t_write

    task automatic rd(input logic [2:0] a, input logic il);
        logic [2:0] ea;
        idle();
        cs = 1'b0;
        sel = 3'h0;
        @(negedge clk);
        idle();
        oe_n = 1'b0;
        @(negedge clk);
        chk(36'(oe), 36'h0);
        ps = 1'b0;
        addr = 18'h00100 | 18'(a);
        @(negedge clk);
        chk(36'(oe), 36'h0);
        chk(dq, exp[a]);
        idle();
        burst_advance_n = 1'b0;
        for (int k = 1; k < 4; k++) begin
            if (k == 2) begin
                sel = 3'h0;
            end
            if (k == 3) begin
                sel = 3'h6;
                ps = 1'b0;
            end
            @(negedge clk);
            ea = {a[2], il ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k))};
            chk(dq, exp[ea]);
            chk(36'(oe), 36'h1);
            chk(wire_dq, exp[ea]);
        end
        idle();
        oe_n = 1'b1;
        #1;
        chk(36'(oe), 36'h0);
        @(negedge clk);
        $display("burst read from %0d done", a);
    endtask : rd

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // main sequence: linear bursts, then a second reset into interleaved order
    initial begin
        n_tests = 0;
        err_total = 0;
        addr = 18'h00000;
        wdata = 36'h0_0000_0000;
        rst(1'b0);
        t_write();
        rd(3'h0, 1'b0);
        rd(3'h7, 1'b0);
        rst(1'b1);
        rd(3'h5, 1'b1);
        rd(3'h2, 1'b1);
        end_of_test();
    end
endmodule : sync_burst_sram_port_bench
